// >>> rtl/psam_regs.vh
// constants for the program space access mapper
`ifndef PSAM_REGS_VH
`define PSAM_REGS_VH
`define REG_TABLE_PAGE 2'h0
`define REG_VIS_PAGE 2'h1
`define REG_CPU_CONTROL 2'h2
`define REG_STATUS 2'h3
`define CPU_CTRL_CONST_WIN_BIT 2
`define TABLE_PAGE_CFG_BIT 7
`define EA_WINDOW_BIT 15
`define RST_TABLE_PAGE 8'h00
`define RST_VIS_PAGE 8'h00
`define RST_CPU_CONTROL 16'h0000
`define STALL_MOVE 2'h1
`define STALL_OTHER 2'h2
`define STALL_REPEAT_MID 2'h1
`endif

// >>> rtl/program_space_access_mapper.v
// program address generation and data steering for program space access
`timescale 1ns/1ps
`include "psam_regs.vh"

// Notes on behaviour
// - fetch address: bit23 zero, pc, bit0 zero
// - table address is page over full ea
// - table page bit7 selects configuration space
// - configuration space: reads only, writes dropped
// - table accesses need no alignment
// - word low read returns bits 15:0
// - byte low read picks byte by select
// - word high read: upper byte zero
// - byte high read: phantom byte reads zero
// - pc steps by two per word
// - window needs ea15 and enable bit
// - window address: 0, page, ea 14:0
// - data 8000h upward maps onto page
// - window read returns low 16 bits
// - window suspended during table access
// - window stall: move one, others two
// - repeat loop: two at edges, else one
// - table page selects 32k-word region
// - window never reaches configuration space
module program_space_access_mapper (
  input wire clk_i,
  input wire rst_i,
  input wire [1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire fetch_i,
  input wire [22:0] pc_i,
  input wire table_rd_i,
  input wire table_wr_i,
  input wire table_high_i,
  input wire table_byte_i,
  input wire data_rd_i,
  input wire [15:0] ea_i,
  input wire move_instr_i,
  input wire in_repeat_i,
  input wire repeat_edge_i,
  input wire [23:0] prog_rdata_i,
  output reg [23:0] prog_addr_o,
  output reg prog_rd_o,
  output reg prog_wr_o,
  output reg prog_wr_high_o,
  output reg [1:0] prog_wr_lanes_o,
  output reg [15:0] data_o,
  output reg data_valid_o,
  output reg data_to_prog_o,
  output reg [1:0] stall_o,
  output reg wr_refused_o
);

  // software visible registers
  reg [7:0] table_page_reg;
  reg [7:0] visibility_page_reg;
  reg [15:0] cpu_control_reg;

  // what the read in flight needs one cycle later
  reg [1:0] rd_kind;
  reg rd_byte_sel;
  reg rd_pending;
  reg table_byte_hold;

  // next values of the registered outputs
  reg [1:0] next_rd_kind;
  reg [15:0] next_reg_rdata;
  reg [23:0] next_prog_addr;
  reg next_prog_rd;
  reg next_prog_wr;
  reg next_prog_wr_high;
  reg [1:0] next_prog_wr_lanes;
  reg [1:0] next_stall;
  reg next_wr_refused;
  reg [15:0] next_data;

  localparam [1:0] KIND_LOW = 2'h0;
  localparam [1:0] KIND_HIGH = 2'h1;
  localparam [1:0] KIND_WIN = 2'h2;

  wire const_window_enable = cpu_control_reg[`CPU_CTRL_CONST_WIN_BIT];
  wire table_busy = table_rd_i | table_wr_i;
  wire cfg_space = table_page_reg[`TABLE_PAGE_CFG_BIT];
  wire win_hit = data_rd_i & ea_i[`EA_WINDOW_BIT] &
    const_window_enable & ~table_busy;
  wire [23:0] table_addr = {table_page_reg, ea_i};
  wire [23:0] win_addr = {1'b0, visibility_page_reg, ea_i[14:0]};
  wire [23:0] fetch_addr = {1'b0, pc_i[22:1], 1'b0};
  wire table_wr_ok = table_wr_i & ~cfg_space;
  wire [1:0] byte_lanes;

  // one write enable per byte lane; byte mode picks a lane by ea bit 0
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1)
    begin : g_lane
      assign byte_lanes[lane] = ~table_byte_i | (ea_i[0] == (lane == 1));
    end
  endgenerate

  // register writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      table_page_reg <= `RST_TABLE_PAGE;
      visibility_page_reg <= `RST_VIS_PAGE;
      cpu_control_reg <= `RST_CPU_CONTROL;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `REG_TABLE_PAGE:
        begin
          table_page_reg <= reg_wdata_i[7:0];
        end
        `REG_VIS_PAGE:
        begin
          visibility_page_reg <= reg_wdata_i[7:0];
        end
        `REG_CPU_CONTROL:
        begin
          cpu_control_reg <= reg_wdata_i;
        end
        default:
        begin
        end
      endcase
    end
  end

  // read data, zero outside the cycle after a read strobe
  always @*
  begin
    next_reg_rdata = 16'h0000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `REG_TABLE_PAGE:
        begin
          next_reg_rdata = {8'h00, table_page_reg};
        end
        `REG_VIS_PAGE:
        begin
          next_reg_rdata = {8'h00, visibility_page_reg};
        end
        `REG_CPU_CONTROL:
        begin
          next_reg_rdata = cpu_control_reg;
        end
        `REG_STATUS:
        begin
          next_reg_rdata = {13'h0000, rd_pending, win_hit, wr_refused_o};
        end
        default:
        begin
          next_reg_rdata = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else
    begin
      reg_rdata_o <= next_reg_rdata;
    end
  end

  // kind of read whose word comes back next cycle
  always @*
  begin
    next_rd_kind = KIND_LOW;
    if (win_hit)
    begin
      next_rd_kind = KIND_WIN;
    end
    else if (table_high_i)
    begin
      next_rd_kind = KIND_HIGH;
    end
  end

  // next request toward memory; table beats window beats fetch
  always @*
  begin
    next_prog_addr = prog_addr_o;
    next_prog_rd = 1'b0;
    next_prog_wr = 1'b0;
    next_prog_wr_high = prog_wr_high_o;
    next_prog_wr_lanes = prog_wr_lanes_o;
    next_stall = 2'h0;
    next_wr_refused = wr_refused_o;
    if (table_busy)
    begin
      next_prog_addr = table_addr;
      next_prog_rd = table_rd_i;
      next_prog_wr = table_wr_ok;
      next_prog_wr_high = table_high_i;
      next_prog_wr_lanes = byte_lanes;
      next_wr_refused = table_wr_i & cfg_space;
    end
    else if (win_hit)
    begin
      next_prog_addr = win_addr;
      next_prog_rd = 1'b1;
      if (in_repeat_i)
      begin
        if (repeat_edge_i)
        begin
          next_stall = `STALL_OTHER;
        end
        else
        begin
          next_stall = `STALL_REPEAT_MID;
        end
      end
      else if (move_instr_i)
      begin
        next_stall = `STALL_MOVE;
      end
      else
      begin
        next_stall = `STALL_OTHER;
      end
    end
    else if (fetch_i)
    begin
      next_prog_addr = fetch_addr;
      next_prog_rd = 1'b1;
    end
  end

  // registered outputs toward memory and the core
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prog_addr_o <= 24'h000000;
      prog_rd_o <= 1'b0;
      prog_wr_o <= 1'b0;
      prog_wr_high_o <= 1'b0;
      prog_wr_lanes_o <= 2'h0;
      data_to_prog_o <= 1'b0;
      stall_o <= 2'h0;
      wr_refused_o <= 1'b0;
    end
    else
    begin
      prog_addr_o <= next_prog_addr;
      prog_rd_o <= next_prog_rd;
      prog_wr_o <= next_prog_wr;
      prog_wr_high_o <= next_prog_wr_high;
      prog_wr_lanes_o <= next_prog_wr_lanes;
      data_to_prog_o <= win_hit;
      stall_o <= next_stall;
      wr_refused_o <= next_wr_refused;
    end
  end

  // read tracking, so the word can be steered when it returns
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_pending <= 1'b0;
      rd_kind <= KIND_LOW;
      rd_byte_sel <= 1'b0;
      table_byte_hold <= 1'b0;
    end
    else
    begin
      rd_pending <= table_rd_i | win_hit;
      rd_kind <= next_rd_kind;
      rd_byte_sel <= ea_i[0];
      table_byte_hold <= table_busy & table_byte_i;
    end
  end

  // steering of the returned word, one cycle after the address
  always @*
  begin
    next_data = data_o;
    if (rd_pending)
    begin
      case (rd_kind)
        KIND_WIN:
        begin
          next_data = prog_rdata_i[15:0];
        end
        KIND_HIGH:
        begin
          if (table_byte_hold && rd_byte_sel)
          begin
            next_data = 16'h0000;
          end
          else
          begin
            next_data = {8'h00, prog_rdata_i[23:16]};
          end
        end
        KIND_LOW:
        begin
          if (!table_byte_hold)
          begin
            next_data = prog_rdata_i[15:0];
          end
          else if (rd_byte_sel)
          begin
            next_data = {8'h00, prog_rdata_i[15:8]};
          end
          else
          begin
            next_data = {8'h00, prog_rdata_i[7:0]};
          end
        end
        default:
        begin
          next_data = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_o <= 16'h0000;
      data_valid_o <= 1'b0;
    end
    else
    begin
      data_o <= next_data;
      data_valid_o <= rd_pending;
    end
  end

endmodule // program_space_access_mapper

// >>> sim/psam_props.sv
// assertions for the program space access mapper
`timescale 1ns/1ps
module psam_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fetch_i,
  input wire logic table_rd_i,
  input wire logic table_wr_i,
  input wire logic table_high_i,
  input wire logic table_byte_i,
  input wire logic data_rd_i,
  input wire logic move_instr_i,
  input wire logic in_repeat_i,
  input wire logic repeat_edge_i,
  input wire logic prog_rd_o,
  input wire logic prog_wr_o,
  input wire logic prog_wr_high_o,
  input wire logic [1:0] prog_wr_lanes_o,
  input wire logic data_valid_o,
  input wire logic data_to_prog_o,
  input wire logic [1:0] stall_o,
  input wire logic wr_refused_o,
  input wire logic [22:0] pc_i,
  input wire logic [15:0] ea_i,
  input wire logic [15:0] data_o,
  input wire logic [23:0] prog_rdata_i,
  input wire logic [23:0] prog_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] ea_q;
  logic [23:0] rd_q;
  always @(posedge clk_i)
  begin
    ea_q <= ea_i;
    rd_q <= prog_rdata_i;
  end
  sequence s_hi_word;
    table_rd_i && table_high_i && !table_byte_i;
  endsequence
  sequence s_phantom;
    table_rd_i && table_high_i && table_byte_i && ea_i[0];
  endsequence
  a_fetch_addr: assert property (fetch_i && !table_rd_i && !table_wr_i &&
    !data_rd_i |=> prog_rd_o && prog_addr_o == ({1'b0, $past(pc_i)} &
    24'hfffffe)) else $error("fetch address wrong");
  a_table_addr: assert property (table_rd_i |=> prog_rd_o &&
    prog_addr_o[15:0] == ea_q) else $error("table address wrong");
  a_wr_refuse: assert property (table_wr_i |=>
    prog_wr_o != wr_refused_o) else $error("table write outcome wrong");
  a_wr_user: assert property (prog_wr_o |-> !prog_addr_o[23])
    else $error("write reached configuration space");
  a_win_addr: assert property (data_to_prog_o |->
    !prog_addr_o[23] && prog_addr_o[14:0] == ea_q[14:0])
    else $error("window address wrong");
  a_win_off: assert property (data_rd_i && (table_rd_i || table_wr_i ||
    !ea_i[15]) |=> !data_to_prog_o) else $error("window not suppressed");
  a_word_low: assert property (table_rd_i && !table_high_i &&
    !table_byte_i |-> ##2 data_valid_o && data_o == rd_q[15:0])
    else $error("low word read wrong");
  a_high_word: assert property (s_hi_word |-> ##2 data_valid_o &&
    data_o == {8'h00, rd_q[23:16]}) else $error("high word read wrong");
  a_phantom_zero: assert property (s_phantom |-> ##2 data_valid_o &&
    data_o[7:0] == 8'h00) else $error("phantom byte not zero");
  a_win_data: assert property (data_to_prog_o |=> data_valid_o &&
    data_o == rd_q[15:0]) else $error("window data wrong");
  a_win_stall: assert property (data_to_prog_o |-> stall_o ==
    ($past(in_repeat_i) ? ($past(repeat_edge_i) ? 2'h2 : 2'h1) :
    ($past(move_instr_i) ? 2'h1 : 2'h2))) else $error("window stall wrong");
  a_wr_lanes: assert property (table_wr_i |=>
    prog_wr_lanes_o == ($past(table_byte_i) ? (ea_q[0] ? 2'h2 : 2'h1) :
    2'h3) && prog_wr_high_o == $past(table_high_i))
    else $error("write lanes wrong");
endmodule // psam_props
bind program_space_access_mapper psam_props u_props (.*);

// >>> sim/prog_mem_model.sv
// program memory model answering in the cycle of the read strobe
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic clk_i,
  input wire logic prog_rd_o,
  input wire logic [23:0] prog_addr_o,
  output logic [23:0] prog_rdata_i
);
  logic [23:0] junk = 24'h0;
  always @(posedge clk_i)
    junk <= junk + 24'h9e3779;
  // upper byte all ones or all zeros keeps constants nop-safe
  assign prog_rdata_i = prog_rd_o ? {{8{prog_addr_o[1]}},
    prog_addr_o[15:0] ^ {2{prog_addr_o[23:16]}}} : junk;
endmodule // prog_mem_model

// >>> sim/testbench.sv
// self-checking bench for the program space access mapper
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, fetch_i = 0;
  logic table_rd_i = 0, table_wr_i = 0, table_high_i = 0, table_byte_i = 0;
  logic data_rd_i = 0, move_instr_i = 0, in_repeat_i = 0, repeat_edge_i = 0;
  logic [1:0] reg_addr_i = 0, prog_wr_lanes_o, stall_o;
  logic [15:0] reg_wdata_i = 0, ea_i = 0, data_o, reg_rdata_o, e;
  logic [22:0] pc_i = 0;
  logic [23:0] prog_rdata_i, prog_addr_o, a, w;
  logic prog_rd_o, prog_wr_o, prog_wr_high_o, data_valid_o;
  logic data_to_prog_o, wr_refused_o;
  logic [7:0] tp, vp;
  logic [31:0] x;
  logic [31:0] exp_q[$];
  logic [5:0] code[6] = '{6'h11, 6'h12, 6'h14, 6'h16, 6'h01, 6'h20};
  int error_cnt = 0, n_checks = 0, i, k;
  always #5 clk_i = ~clk_i;
  program_space_access_mapper uut (.*);
  prog_mem_model mem (.*);
  task automatic chk(input logic [15:0] g, input logic [15:0] v);
    n_checks++;
    if (g !== v)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, v);
    end
  endtask
  task automatic wreg(input logic [1:0] ad, input logic [15:0] d);
    @(posedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {ad, d, 1'b1};
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic op(input logic [5:0] s, input logic [15:0] ea);
    @(posedge clk_i);
    {fetch_i, table_rd_i, table_wr_i, table_high_i, table_byte_i} <= s[5:1];
    data_rd_i <= s[0];
    ea_i <= ea;
    pc_i <= $urandom;
    {move_instr_i, in_repeat_i, repeat_edge_i} <= $urandom;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
    if (data_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        error_cnt++;
        $display("[ERR] %0t got %h exp %h", $time, data_o, 16'h0);
      end
      else
      begin
        x = exp_q.pop_front();
        chk(data_o & x[31:16], x[15:0]);
      end
    end
  initial
  begin
    i = $urandom(32'h9309a673);
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    tp = $urandom;
    vp = $urandom;
    wreg(2'h0, {8'h00, tp});
    wreg(2'h1, {8'h00, vp});
    wreg(2'h2, 16'h0004);
    @(posedge clk_i);
    {reg_addr_i, reg_rd_i} <= 3'b001;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1;
    chk(reg_rdata_o, {8'h00, tp});
    for (i = 0; i < 200; i++)
    begin
      k = $urandom % 6;
      e = $urandom;
      e[15] = e[15] | (k == 4);
      a = (k == 4) ? {1'b0, vp, e[14:0]} : {tp, e};
      w = {{8{a[1]}}, a[15:0] ^ {2{a[23:16]}}};
      case (k)
        0: exp_q.push_back({16'hffff, w[15:0]});
        1: exp_q.push_back({16'h00ff, 8'h0, e[0] ? w[15:8] : w[7:0]});
        2: exp_q.push_back({16'hffff, 8'h0, w[23:16]});
        3: exp_q.push_back({16'h00ff, 8'h0, e[0] ? 8'h0 : w[23:16]});
        4: exp_q.push_back({16'hffff, w[15:0]});
        default: ;
      endcase
      op(code[k], e);
    end
    op(6'h00, e);
    for (i = 0; i < 2; i++)
    begin
      wreg(2'h0, i ? 16'h0001 : 16'h0080);
      op({3'b001, i[0], ~i[0], 1'b0}, e);
      op(6'h00, e);
      #1;
      chk({prog_wr_o, wr_refused_o}, i ? 2'b10 : 2'b01);
    end
    repeat (4) @(posedge clk_i);
    if (exp_q.size() != 0)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, exp_q.size(), 32'h0);
    end
    wrap_up();
  end
endmodule // testbench
